// file: rtl/ufa_flash.sv
// Flash block end: serial address/data registers, array, busy, osc.
// Assumes the user end keeps link clocks slow enough to sample.
`timescale 1ns/100ps
`default_nettype none
module ufa_flash
    import ufa_pkg::*;
#(
    parameter int P_ERASE_BUSY_CYC = ERASE_BUSY_CYC
) (
    input  wire logic  i_clk_sys,
    input  wire logic  i_rstn,
    ufa_link_if.flash  lnk,
    output logic       o_busy
);
    ufa_flash_in_s           raw;                 // Pins as bundle
    ufa_flash_in_s           lvl;                 // Synced levels
    ufa_flash_in_s           rise;                // Synced rises
    ufa_flash_e              state_r;             // Operation state
    logic [31:0]             cnt_r;               // Busy length
    logic [ADDR_W-1:0]       areg_r;              // Address register
    logic [DATA_W-1:0]       dreg_r;              // Data register
    logic [DATA_W-1:0]       mem_r [MEM_DEPTH];   // Flash array
    logic [7:0]              oe_r;                // Osc start delay
    logic [7:0]              div_r;               // Osc divider
    logic                    prog_go;             // Program starts
    logic                    erase_go;            // Erase starts
    logic                    op_end;              // Busy ends

    assign raw = {lnk.arclk, lnk.ardin, lnk.arshft, lnk.drclk,
                  lnk.drdin, lnk.drshft, lnk.prog_strobe, lnk.erase,
                  lnk.oscillator_enable_request};

    // All link inputs through one synchroniser
    ufa_sync #(.W($bits(ufa_flash_in_s))) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_d       (raw),
        .o_q       (lvl),
        .o_rise    (rise),
        .o_fall    ()
    );

    assign prog_go  = (state_r == F_IDLE) && rise.prog_strobe;
    assign erase_go = (state_r == F_IDLE) && !rise.prog_strobe && rise.erase;
    assign op_end   = ((state_r == F_PROG) &&
                       (cnt_r == 32'(PROG_BUSY_CYC - 1))) ||
                      ((state_r == F_ERASE) &&
                       (cnt_r == 32'(P_ERASE_BUSY_CYC - 1)));

    // Address shift register
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            areg_r <= '0;
        end else if (rise.arclk && lvl.arshft) begin
            areg_r <= {areg_r[ADDR_W-2:0], lvl.ardin};
        end
    end

    // Data register: load or shift on data clock
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            dreg_r <= '0;
        end else if (rise.drclk) begin
            if (!lvl.drshft) begin
                dreg_r <= mem_r[areg_r];
            end else begin
                dreg_r <= {dreg_r[DATA_W-2:0], lvl.drdin};
            end
        end
    end

    // Serial output bit
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            lnk.drdout <= 1'b0;
        end else begin
            lnk.drdout <= dreg_r[DATA_W-1];
        end
    end

    // Operation state and busy length counter
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= F_IDLE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                F_IDLE: begin
                    cnt_r <= '0;
                    if (prog_go) begin
                        state_r <= F_PROG;
                    end else if (erase_go) begin
                        state_r <= F_ERASE;
                    end
                end
                F_PROG, F_ERASE: begin
                    if (op_end) begin
                        state_r <= F_IDLE;
                    end
                    cnt_r <= cnt_r + 32'h1;
                end
                default: begin
                    state_r <= F_IDLE;
                end
            endcase
        end
    end

    // Busy flag, one cycle after detected strobe
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            lnk.busy <= 1'b0;
            o_busy   <= 1'b0;
        end else begin
            if (prog_go || erase_go) begin
                lnk.busy <= 1'b1;
                o_busy   <= 1'b1;
            end else if (op_end) begin
                lnk.busy <= 1'b0;
                o_busy   <= 1'b0;
            end
        end
    end

    // Array: program at start, erase at end
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_r[i] <= MEM_ERASED;
            end
        end else if (prog_go) begin
            mem_r[areg_r] <= dreg_r;
        end else if (op_end && (state_r == F_ERASE)) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_r[i] <= MEM_ERASED;
            end
        end
    end

    // Oscillator with start delay after enable
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            oe_r    <= '0;
            div_r   <= '0;
            lnk.osc <= 1'b0;
        end else if (!lvl.oscillator_enable_request) begin
            oe_r    <= '0;
            div_r   <= '0;
            lnk.osc <= 1'b0;
        end else if (oe_r != 8'(OE_MIN_CYC)) begin
            oe_r <= oe_r + 8'h1;
        end else if (div_r == 8'(OSC_HALF_CYC - 1)) begin
            div_r   <= '0;
            lnk.osc <= ~lnk.osc;
        end else begin
            div_r <= div_r + 8'h1;
        end
    end
endmodule
`default_nettype wire

// file: rtl/ufa_host.sv
// User logic end: sequences read, program and erase on the flash link.
// Assumes a single request at a time, taken only while o_ready is high.
`timescale 1ns/100ps
`default_nettype none
module ufa_host
    import ufa_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    ufa_link_if.user               lnk,
    input  wire logic              i_start,
    input  wire logic [1:0]        i_op,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic                   o_ready,
    output logic                   o_done,
    output logic      [DATA_W-1:0] o_rdata
);
    ufa_host_e          state_r;     // Sequencer state
    ufa_host_e          state_nxt;   // Next state
    logic [1:0]         op_r;        // Latched operation
    logic [ADDR_W-1:0]  ash_r;       // Address shift out
    logic [DATA_W-1:0]  dsh_r;       // Data shift out
    logic [DATA_W-1:0]  rsh_r;       // Read bits gathered
    logic [7:0]         ph_r;        // Phase in link clock
    logic [4:0]         bit_r;       // Bit index in phase
    logic [7:0]         tmr_r;       // State timer
    logic               busy_s;      // Synced busy
    logic               dout_s;      // Synced data out
    logic               busy_rise;   // Busy rising edge
    logic               ph_last;     // Last cycle of a bit
    logic               ph_pre;      // Cycle before rise
    logic               shifting;    // In a serial state
    logic               last_bit;    // Final bit of phase
    logic               unused_rise; // Data-out edge, not needed

    // Flash outputs into our domain
    ufa_sync #(.W(2)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_d       ({lnk.busy, lnk.drdout}),
        .o_q       ({busy_s, dout_s}),
        .o_rise    ({busy_rise, unused_rise}),
        .o_fall    ()
    );

    assign shifting = (state_r == H_ADDR) || (state_r == H_DLOAD) ||
                      (state_r == H_DATA);
    assign ph_last  = (ph_r == 8'(2 * LINK_HALF_CYC - 1));
    assign ph_pre   = (ph_r == 8'(LINK_HALF_CYC - 1));
    assign last_bit = ((state_r == H_ADDR) &&
                       (bit_r == 5'(ADDR_W - 1))) ||
                      (state_r == H_DLOAD) ||
                      ((state_r == H_DATA) &&
                       (bit_r == 5'(DATA_W - 1)));

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            H_IDLE: begin
                if (i_start && !busy_s) begin
                    state_nxt = H_ADDR;
                end
            end
            H_ADDR: begin
                if (ph_last && last_bit) begin
                    if (op_r == OP_READ) begin
                        state_nxt = H_DLOAD;
                    end else if (op_r == OP_PROG) begin
                        state_nxt = H_DATA;
                    end else begin
                        state_nxt = H_OSC_LEAD;
                    end
                end
            end
            H_DLOAD: begin
                if (ph_last) begin
                    state_nxt = H_DATA;
                end
            end
            H_DATA: begin
                if (ph_last && last_bit) begin
                    state_nxt = (op_r == OP_READ) ? H_DONE : H_OSC_LEAD;
                end
            end
            H_OSC_LEAD: begin
                if (tmr_r == 8'(OSC_SETUP_CYC - 1)) begin
                    state_nxt = H_WAIT_HI;
                end
            end
            H_WAIT_HI: begin
                if (busy_rise || (tmr_r == 8'(BUSY_WAIT_CYC - 1))) begin
                    state_nxt = H_WAIT_LO;
                end
            end
            H_WAIT_LO: begin
                if (!busy_s) begin
                    state_nxt = H_HOLD;
                end
            end
            H_HOLD: begin
                if (tmr_r == 8'(BP_CYC - 1)) begin
                    state_nxt = H_OSC_TRAIL;
                end
            end
            H_OSC_TRAIL: begin
                if (tmr_r == 8'(OSC_HOLD_CYC - 1)) begin
                    state_nxt = H_DONE;
                end
            end
            H_DONE: begin
                state_nxt = H_IDLE;
            end
            default: begin
                state_nxt = H_IDLE;
            end
        endcase
    end

    // State register and timer
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= H_IDLE;
            tmr_r   <= '0;
        end else begin
            state_r <= state_nxt;
            tmr_r   <= (state_nxt != state_r) ? 8'h0 : tmr_r + 8'h1;
        end
    end

    // Link clock phase and bit counters
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ph_r  <= '0;
            bit_r <= '0;
        end else if (!shifting || (state_nxt != state_r)) begin
            ph_r  <= '0;
            bit_r <= '0;
        end else if (ph_last) begin
            ph_r  <= '0;
            bit_r <= bit_r + 5'h1;
        end else begin
            ph_r <= ph_r + 8'h1;
        end
    end

    // Latch request, shift address and data out, gather read bits
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            op_r  <= OP_READ;
            ash_r <= '0;
            dsh_r <= '0;
            rsh_r <= '0;
        end else if (state_r == H_IDLE) begin
            op_r  <= i_op;
            ash_r <= i_addr;
            dsh_r <= i_wdata;
        end else begin
            if (state_r == H_ADDR && ph_last) begin
                ash_r <= {ash_r[ADDR_W-2:0], 1'b0};
            end
            if (state_r == H_DATA && ph_last) begin
                dsh_r <= {dsh_r[DATA_W-2:0], 1'b0};
            end
            if (state_r == H_DATA && ph_pre) begin
                rsh_r <= {rsh_r[DATA_W-2:0], dout_s};
            end
        end
    end

    // Serial link pins, high phase after half period
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            lnk.arclk  <= 1'b0;
            lnk.ardin  <= 1'b0;
            lnk.arshft <= 1'b0;
            lnk.drclk  <= 1'b0;
            lnk.drdin  <= 1'b0;
            lnk.drshft <= 1'b0;
        end else begin
            lnk.arclk  <= (state_r == H_ADDR) && ph_pre ? 1'b1 :
                          ph_last ? 1'b0 : lnk.arclk;
            lnk.drclk  <= ((state_r == H_DLOAD) || (state_r == H_DATA)) &&
                          ph_pre ? 1'b1 : ph_last ? 1'b0 : lnk.drclk;
            lnk.ardin  <= ash_r[ADDR_W-1];
            lnk.arshft <= (state_r == H_ADDR);
            lnk.drdin  <= dsh_r[DATA_W-1];
            lnk.drshft <= (state_r == H_DATA);
        end
    end

    // Strobes and oscillator enable
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            lnk.prog_strobe <= 1'b0;
            lnk.erase   <= 1'b0;
            lnk.oscillator_enable_request <= 1'b0;
        end else begin
            lnk.oscillator_enable_request <= (state_nxt == H_OSC_LEAD) ||
                           (state_nxt == H_WAIT_HI) ||
                           (state_nxt == H_WAIT_LO) ||
                           (state_nxt == H_HOLD) ||
                           (state_nxt == H_OSC_TRAIL);
            lnk.prog_strobe <= (op_r == OP_PROG) &&
                           ((state_nxt == H_WAIT_HI) ||
                            (state_nxt == H_WAIT_LO) ||
                            (state_nxt == H_HOLD));
            lnk.erase   <= (op_r == OP_ERASE) &&
                           ((state_nxt == H_WAIT_HI) ||
                            (state_nxt == H_WAIT_LO) ||
                            (state_nxt == H_HOLD));
        end
    end

    // User side answers
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ready <= 1'b0;
            o_done  <= 1'b0;
            o_rdata <= '0;
        end else begin
            o_ready <= (state_nxt == H_IDLE);
            o_done  <= (state_nxt == H_DONE);
            if (state_r == H_DATA && state_nxt == H_DONE) begin
                o_rdata <= rsh_r;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/ufa_link_if.sv
// Link between user logic and the user flash block.
// Assumes both ends share one system clock domain.
`timescale 1ns/100ps
`default_nettype none
interface ufa_link_if;
    logic arclk;    // Address register clock
    logic ardin;    // Address serial data
    logic arshft;   // Address shift enable
    logic drclk;    // Data register clock
    logic drdin;    // Data serial in
    logic drshft;   // Data shift, low loads from array
    logic drdout;   // Data serial out
    logic prog_strobe; // Program strobe
    logic erase;    // Erase strobe
    logic busy;     // Flash busy flag
    logic oscillator_enable_request;  // Oscillator enable request
    logic osc;      // Flash oscillator output

    modport flash (
        input  arclk, ardin, arshft, drclk, drdin, drshft,
        input  prog_strobe, erase, oscillator_enable_request,
        output drdout, busy, osc
    );
    modport user (
        output arclk, ardin, arshft, drclk, drdin, drshft,
        output prog_strobe, erase, oscillator_enable_request,
        input  drdout, busy
    );
endinterface
`default_nettype wire

// file: rtl/ufa_pkg.sv
// Package for the user flash access sequencer: widths, timing, types.
// Assumes one system clock of 20 MHz on both ends of the link.
// Contract
// - Address clock period never below minimum
// - Data clock period never below minimum
// - Next data bit out promptly after clock
// - Read data ready soon after address load
// - Busy rises soon after program strobe
// - Program held until shortly after busy falls
// - Program busy pulse bounded in length
// - Busy rises soon after erase strobe
// - Erase held until shortly after busy falls
// - Erase busy pulse bounded in length
// - Oscillator enabled well before the strobe
// - Oscillator kept on after the strobe
// - First oscillator edge not too early
package ufa_pkg;
    // Array shape
    localparam int ADDR_W    = 9;
    localparam int DATA_W    = 16;
    localparam int MEM_DEPTH = 512;
    localparam logic [15:0] MEM_ERASED = 16'hFFFF;

    // System clock
    localparam int CLK_PERIOD_NS = 50;

    // Serial link clocks: floor and chosen period
    localparam int LINK_CLK_MIN_NS    = 100;
    localparam int LINK_CLK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC =
        (LINK_CLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Device answer times, longest, rounded down; DCO and RA at least one cycle
    localparam int DCO_MAX_NS = 5;
    localparam int DCO_CYC = (DCO_MAX_NS / CLK_PERIOD_NS > 0) ?
                             DCO_MAX_NS / CLK_PERIOD_NS : 1;
    localparam int RA_MAX_NS = 65;
    localparam int RA_CYC = (RA_MAX_NS / CLK_PERIOD_NS > 0) ?
                            RA_MAX_NS / CLK_PERIOD_NS : 1;
    localparam int PB_MAX_NS  = 960;
    localparam int PB_MAX_CYC = PB_MAX_NS / CLK_PERIOD_NS;
    localparam int PROG_BUSY_MAX_US = 100;
    localparam int PROG_BUSY_CYC =
        PROG_BUSY_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int ERASE_BUSY_MAX_MS = 500;
    localparam int ERASE_BUSY_CYC =
        ERASE_BUSY_MAX_MS * 1000000 / CLK_PERIOD_NS;

    // Least times, rounded up
    localparam int BP_MIN_NS = 20;
    localparam int BP_CYC =
        (BP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_SETUP_NS = 250;
    localparam int OSC_SETUP_CYC =
        (OSC_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_HOLD_NS = 250;
    localparam int OSC_HOLD_CYC =
        (OSC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OE_MIN_NS = 180;
    localparam int OE_MIN_CYC =
        (OE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_HALF_CYC = 2;

    // Host gives up on busy rise after this, sync lag included
    localparam int BUSY_WAIT_CYC = PB_MAX_CYC + 4;

    // Operation codes on the user side of the host
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_PROG  = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;

    // Link inputs as the flash end sees them
    typedef struct packed {
        logic arclk;
        logic ardin;
        logic arshft;
        logic drclk;
        logic drdin;
        logic drshft;
        logic prog_strobe;
        logic erase;
        logic oscillator_enable_request;
    } ufa_flash_in_s;

    // Host sequencer states
    typedef enum {
        H_IDLE, H_ADDR, H_DLOAD, H_DATA, H_OSC_LEAD,
        H_WAIT_HI, H_WAIT_LO, H_HOLD, H_OSC_TRAIL, H_DONE
    } ufa_host_e;

    // Flash block states
    typedef enum {F_IDLE, F_PROG, F_ERASE} ufa_flash_e;
endpackage

// file: rtl/ufa_sync.sv
// Two-flop synchroniser with edge detection for a bundle of inputs.
// Assumes inputs are asynchronous levels; outputs are system-clocked.
`timescale 1ns/100ps
`default_nettype none
module ufa_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    logic [W-1:0] s1_r;   // First stage, read only by s2
    logic [W-1:0] s2_r;   // Second stage, safe level
    logic [W-1:0] s3_r;   // Previous level for edges

    // Synchroniser chain
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Level and edges
    assign o_q    = s2_r;
    assign o_rise = s2_r & ~s3_r;
    assign o_fall = ~s2_r & s3_r;
endmodule
`default_nettype wire

// file: sim/test_user_flash_access_sequencer.sv
// Bench: host end drives flash end over the link; wire is watched.
// Assumes the host user side contract and a 20 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module test_user_flash_access_sequencer
    import ufa_pkg::*;
;
    localparam int ERASE_CYC = 50;   // Short erase busy
    logic              i_clk_sys;    // System clock
    logic              i_rstn;       // Reset, active low
    logic              i_start;      // Request level
    logic [1:0]        i_op;         // Operation code
    logic [ADDR_W-1:0] i_addr;       // Word address
    logic [DATA_W-1:0] i_wdata;      // Program word
    logic              o_ready;      // Host idle
    logic              o_done;       // End pulse
    logic              o_busy;       // Flash busy copy
    logic [DATA_W-1:0] o_rdata;      // Read word
    logic [15:0]       ar_sh;        // Address bits on wire
    logic [15:0]       dr_sh;        // Data bits on wire
    int                fails;        // Mismatches
    int                comparisons;  // Compares made
    int                n_ar;         // Address clock rises
    int                n_dr;         // Data shift clock rises
    int                n_ld;         // Data load clock rises
    int                n_osc;        // Oscillator rises
    int                n_busy;       // Busy cycles
    ufa_link_if lnk ();
    ufa_flash #(.P_ERASE_BUSY_CYC(ERASE_CYC)) u_ufa_flash (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .lnk(lnk), .o_busy(o_busy));
    ufa_host u_ufa_host (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .lnk(lnk),
        .i_start(i_start), .i_op(i_op), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done),
        .o_rdata(o_rdata));
    ufa_monitor #(.P_ERASE_BUSY_CYC(ERASE_CYC)) u_ufa_monitor (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_arclk(lnk.arclk),
        .i_drclk(lnk.drclk), .i_prog_strobe(lnk.prog_strobe),
        .i_erase(lnk.erase), .i_busy(lnk.busy), .i_oscillator_enable_request(lnk.oscillator_enable_request),
        .i_osc(lnk.osc));
    // Clock at 50 ns
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    // Wire watchers
    always @(posedge lnk.arclk) begin
        n_ar++;
        ar_sh = {ar_sh[14:0], lnk.ardin};
    end
    always @(posedge lnk.drclk) begin
        if (lnk.drshft) begin
            n_dr++;
            dr_sh = {dr_sh[14:0], lnk.drdin};
        end else begin
            n_ld++;
        end
    end
    always @(posedge lnk.osc) n_osc++;
    always @(posedge i_clk_sys) if (lnk.busy === 1'b1) n_busy++;
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Verdict and end
    task results;
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One host request, bounded waits
    task run_op(input logic [1:0] op, input logic [8:0] a,
                input logic [15:0] d);
        int k;
        k = 0;
        n_ar = 0;
        n_dr = 0;
        n_ld = 0;
        n_osc = 0;
        n_busy = 0;
        @(negedge i_clk_sys);
        i_op = op;
        i_addr = a;
        i_wdata = d;
        i_start = 1'b1;
        while (o_ready !== 1'b0 && k < 20) begin
            @(negedge i_clk_sys);
            k++;
        end
        check(o_ready, 32'h0);
        i_start = 1'b0;
        while (o_done !== 1'b1 && k < 5000) begin
            @(negedge i_clk_sys);
            k++;
        end
        if (k >= 5000) begin
            fails++;
            results();
        end
        check(n_ar, 32'h9);
        check(ar_sh[8:0], a);
    endtask
    // Read a word, wire framing and data
    task t_read(input logic [8:0] a, input logic [15:0] exp);
        run_op(OP_READ, a, 16'h0000);
        check(n_ld, 32'h1);
        check(n_dr, 32'h10);
        check(o_rdata, exp);
    endtask
    // Program a word, busy bounded, oscillator running
    task t_prog(input logic [8:0] a, input logic [15:0] d);
        run_op(OP_PROG, a, d);
        check(n_dr, 32'h10);
        check(dr_sh, d);
        check(n_busy > 0 && n_busy <= PROG_BUSY_CYC, 32'h1);
        check(n_osc > 0, 32'h1);
    endtask
    // Erase whole array
    task t_erase;
        run_op(OP_ERASE, 9'h0AA, 16'h0000);
        check(n_busy > 0 && n_busy <= ERASE_CYC, 32'h1);
    endtask
    // Reset during program busy clears link and array
    task t_reset_mid;
        int k;
        k = 0;
        run_op(OP_READ, 9'h055, 16'h0000);
        i_op = OP_PROG;
        i_wdata = 16'h1234;
        @(negedge i_clk_sys);
        i_start = 1'b1;
        while (o_ready !== 1'b0 && k < 20) begin
            @(negedge i_clk_sys);
            k++;
        end
        i_start = 1'b0;
        repeat (250) @(negedge i_clk_sys);
        check(lnk.busy, 32'h1);
        check(o_busy, 32'h1);
        i_rstn = 1'b0;
        @(negedge i_clk_sys);
        check(lnk.prog_strobe, 32'h0);
        check(o_ready, 32'h0);
        i_rstn = 1'b1;
        t_read(9'h055, 16'hFFFF);
    endtask
    // Main sequence
    initial begin
        i_rstn = 1'b0;
        i_start = 1'b0;
        i_op = OP_READ;
        i_addr = '0;
        i_wdata = '0;
        fails = 0;
        comparisons = 0;
        repeat (5) @(negedge i_clk_sys);
        i_rstn = 1'b1;
        t_read(9'h1FF, 16'hFFFF);
        t_prog(9'h1FF, 16'hA5C3);
        t_prog(9'h000, 16'h0001);
        t_read(9'h1FF, 16'hA5C3);
        t_read(9'h000, 16'h0001);
        t_erase;
        t_read(9'h1FF, 16'hFFFF);
        t_read(9'h000, 16'hFFFF);
        t_reset_mid;
        results();
    end
endmodule
`default_nettype wire

// file: sim/ufa_monitor.sv
// Checker for the flash link: strobes, busy and clock timing.
// Assumes one system clock on both link ends, reset active low.
`timescale 1ns/100ps
`default_nettype none
module ufa_monitor
    import ufa_pkg::*;
#(
    parameter int P_ERASE_BUSY_CYC = ERASE_BUSY_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_arclk,
    input wire logic i_drclk,
    input wire logic i_prog_strobe,
    input wire logic i_erase,
    input wire logic i_busy,
    input wire logic i_oscillator_enable_request,
    input wire logic i_osc
);
    localparam int PB_WIN = 19;  // Busy rise window, cycles
    logic [31:0] busy_cnt_r;     // Cycles busy has stood
    logic [7:0]  osc_cnt_r;      // Cycles enable has stood
    logic        osc_up_r;       // Oscillator rose since enable
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // Busy length counter
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= i_busy ? busy_cnt_r + 32'h1 : 32'h0;
        end
    end
    // Enable age counter, saturating
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_cnt_r <= '0;
        end else begin
            osc_cnt_r <= i_oscillator_enable_request ? osc_cnt_r + {7'h0, ~&osc_cnt_r} : 8'h0;
        end
    end
    // First rise per enable; later rises ride on synced enable lag
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_up_r <= 1'b0;
        end else if (i_oscillator_enable_request && (osc_cnt_r == 8'h0)) begin
            osc_up_r <= 1'b0;
        end else if (i_osc) begin
            osc_up_r <= 1'b1;
        end
    end
    a_addr_clk_gap: assert property (
        $rose(i_arclk) |=> !$rose(i_arclk)) else $error("address clock fast");
    a_data_clk_gap: assert property (
        $rose(i_drclk) |=> !$rose(i_drclk)) else $error("data clock fast");
    a_prog_busy_rise: assert property (
        $rose(i_prog_strobe) && !i_busy |-> ##[0:PB_WIN] i_busy)
        else $error("busy late after program");
    a_erase_busy_rise: assert property (
        $rose(i_erase) && !i_busy |-> ##[0:PB_WIN] i_busy)
        else $error("busy late after erase");
    a_prog_hold: assert property (
        $fell(i_prog_strobe) |-> !i_busy && !$past(i_busy))
        else $error("program dropped early");
    a_erase_hold: assert property (
        $fell(i_erase) |-> !i_busy && !$past(i_busy))
        else $error("erase dropped early");
    a_prog_busy_len: assert property (
        i_busy && i_prog_strobe |-> busy_cnt_r < PROG_BUSY_CYC)
        else $error("program busy too long");
    a_erase_busy_len: assert property (
        i_busy && i_erase |-> busy_cnt_r < P_ERASE_BUSY_CYC)
        else $error("erase busy too long");
    a_osc_lead: assert property (
        $rose(i_prog_strobe || i_erase) |-> osc_cnt_r >= OSC_SETUP_CYC)
        else $error("oscillator lead short");
    a_osc_trail: assert property (
        $fell(i_oscillator_enable_request) |-> !$past(i_prog_strobe, 5) && !$past(i_erase, 5))
        else $error("oscillator trail short");
    a_osc_first_edge: assert property (
        $rose(i_osc) && !osc_up_r |-> osc_cnt_r >= OE_MIN_CYC)
        else $error("oscillator edge early");
endmodule
`default_nettype wire
